// File: src/single_wire_master.sv
// What this block does
// - write to data address fills tx holding; read returns rx holding
// - tx byte moves to shifter, sent least significant bit first
// - empty shifter with full holding register reloads automatically
// - tx_holding_empty set when free, cleared on host write
// - tx_shifter_empty set when idle; load clears it, sets holding empty
// - received bit is wired-AND of sent and slave bit; host sends ones
// - full rx shifter goes to FIFO, flag set; host reads clear it once FIFO empties
// - overdrive_select chooses fast rate when one
// - abort bit stops traffic, resets engines, clears bus reset request, keeps other registers
// - manual pull low works only with permit; blocks other traffic
// - line_sense shows bus level, independent of permit
// - bus reset request pulses bus, clears search, self-clears when done
// - after presence window set presence_seen; result zero if answered
// - search mode: three slots per ROM position, read read write
// - search tx byte: odd bits are path choices, even bits filler
// - written bit: path on conflict, first read otherwise, one if silent
// - search rx byte: odd bits chosen path, even bits discrepancy
// - after bus error chosen bits read one until search cleared
// - manual_drive_permit resets to zero; engine then owns bus
// - presence_seen resets to zero, cleared by status read
//
// holds the receive FIFO and the bus master datapath top
// assumes host pins asynchronous to clock and an external pull-up on the line
`timescale 1ns/1ps
module rx_byte_fifo
  import swm_pkg::*;
#(
  parameter int WIDTH = FIFO_W,
  parameter int DEPTH = FIFO_D
)(
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  assign out_valid = wr_ptr_reg != rd_ptr_reg;
  assign in_ready = !((wr_ptr_reg[AW] != rd_ptr_reg[AW])
                      && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
  assign out_data = mem[rd_ptr_reg[AW-1:0]];
  always_ff @(posedge clock)
  begin
    if (clock_en && in_valid && in_ready)
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
  end
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else if (clock_en)
    begin
      if (in_valid && in_ready)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (out_valid && out_ready)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule

module single_wire_master
  import swm_pkg::*;
#(
  parameter logic [15:0] RST_LOW_CYC = RSTL_STD_CYC,
  parameter logic [15:0] RST_WAIT_CYC = RSTW_STD_CYC
)(
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_en,
  input wire logic [2:0] addr,
  input wire logic en_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic dq_in,
  output logic dq_out,
  output logic dq_oe
);
  logic [14:0] pin_s1, pin_s2;
  logic wr_prev, rd_prev;
  logic od_reg, abort_reg, pull_reg, sra_reg, brr_reg;
  logic [7:0] ien_reg, tx_hold_reg, tx_shift_reg, rx_shift_reg;
  logic tbe_reg, tx_shifter_empty_reg, pd_reg, pdr_reg, pres_reg;
  logic wbit_reg, b0_reg, b2_reg, err_reg;
  logic [15:0] cnt_reg;
  logic [2:0] bit_reg;
  logic [1:0] sub_reg;
  eng_state_e state_reg;
  logic [7:0] data_out_reg;
  logic data_oe_reg, dq_oe_reg, dq_out_reg;
  logic [2:0] addr_s;
  logic [7:0] data_s;
  logic sense, wr_act, rd_act, wr_start, rd_start;
  logic manual_active, idle_go, start_rst, start_slot, load_now;
  logic slot_end, samp, last_slot, push, rst_done, pop, nbsy, slot_bit;
  logic fifo_ready, rx_holding_full;
  logic [7:0] rx_hold;
  logic [15:0] slot_len, low_len, samp_pt, rstl_len, rstw_len, pres_pt;
  logic none, conflict, b2, path;

  assign {addr_s, data_s} = pin_s2[14:4];
  assign sense = pin_s2[0];
  assign wr_act = !pin_s2[3] && !pin_s2[1];
  // write strobe wins when both are low
  assign rd_act = !pin_s2[3] && !pin_s2[2] && pin_s2[1];
  assign wr_start = wr_act && !wr_prev;
  assign rd_start = rd_act && !rd_prev;
  assign data_out = data_out_reg;
  assign data_oe = data_oe_reg;
  assign dq_oe = dq_oe_reg;
  assign dq_out = dq_out_reg;

  // every pin passes two flops before use
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pin_s1 <= PIN_IDLE;
      pin_s2 <= PIN_IDLE;
      wr_prev <= 1'b0;
      rd_prev <= 1'b0;
    end
    else if (clock_en)
    begin
      pin_s1 <= {addr, data_in, en_n, rd_n, wr_n, dq_in};
      pin_s2 <= pin_s1;
      wr_prev <= wr_act;
      rd_prev <= rd_act;
    end
  end

  always_comb
  begin
    slot_len = od_reg ? SLOT_OD_CYC : SLOT_STD_CYC;
    samp_pt = od_reg ? SAMP_OD_CYC : SAMP_STD_CYC;
    rstl_len = od_reg ? RSTL_OD_CYC : RST_LOW_CYC;
    rstw_len = od_reg ? RSTW_OD_CYC : RST_WAIT_CYC;
    pres_pt = od_reg ? PRES_OD_CYC : PRES_STD_CYC;
    if (wbit_reg)
      low_len = od_reg ? LOW1_OD_CYC : LOW1_STD_CYC;
    else
      low_len = od_reg ? LOW0_OD_CYC : LOW0_STD_CYC;
  end

  // manual drive needs permit and stalls the engine
  assign manual_active = ien_reg[B_PERMIT] && pull_reg;
  assign idle_go = state_reg == ST_IDLE && !abort_reg && !manual_active;
  assign start_rst = idle_go && brr_reg;
  assign start_slot = idle_go && !brr_reg && !tx_shifter_empty_reg;
  // reload only when the receive side has room
  assign load_now = idle_go && !brr_reg && tx_shifter_empty_reg && !tbe_reg && fifo_ready;
  assign slot_end = !abort_reg && state_reg == ST_SLOT && cnt_reg == slot_len - 16'h0001;
  assign samp = !abort_reg && state_reg == ST_SLOT && cnt_reg == samp_pt;
  assign last_slot = sra_reg ? (sub_reg == 2'h2 && bit_reg[1:0] == 2'h3) : bit_reg == 3'h7;
  assign push = slot_end && last_slot;
  assign rst_done = !abort_reg && state_reg == ST_RST_WAIT
                    && cnt_reg == rstw_len - 16'h0001;
  assign pop = rd_start && addr_s == ADDR_DATA;
  assign nbsy = state_reg == ST_IDLE && tx_shifter_empty_reg && !brr_reg && !manual_active;
  // search slots: two reads written as one, then the decision
  assign slot_bit = sra_reg ? (sub_reg == 2'h2 ? b2_reg : 1'b1) : tx_shift_reg[0];

  always_comb
  begin
    none = b0_reg && sense;
    conflict = !b0_reg && !sense;
    // odd bits carry the path choice
    path = tx_shift_reg[{bit_reg[1:0], 1'b1}];
    if (err_reg || none)
      b2 = 1'b1;
    else if (conflict)
      b2 = path;
    else
      b2 = b0_reg;
  end

  // rx holding register is the FIFO head
  rx_byte_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_D)
  ) u_rx_fifo (
    .clock(clock),
    .rst(rst),
    .clock_en(clock_en),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(rx_shift_reg),
    .out_valid(rx_holding_full),
    .out_ready(pop),
    .out_data(rx_hold)
  );

  // command, enable and transmit holding registers
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      od_reg <= 1'b0;
      abort_reg <= 1'b0;
      pull_reg <= 1'b0;
      sra_reg <= 1'b0;
      brr_reg <= 1'b0;
      ien_reg <= IEN_RST;
      tx_hold_reg <= 8'h00;
      tbe_reg <= TBE_RST;
      pd_reg <= 1'b0;
      pdr_reg <= PDR_RST;
    end
    else if (clock_en)
    begin
      // request clears on completion or abort
      if (rst_done || abort_reg)
        brr_reg <= 1'b0;
      if (load_now)
        tbe_reg <= 1'b1;
      // status read clears, a new completion wins
      if (rd_start && addr_s == ADDR_INT)
        pd_reg <= 1'b0;
      if (rst_done)
      begin
        pd_reg <= 1'b1;
        pdr_reg <= !pres_reg;
      end
      if (wr_start && addr_s == ADDR_CMD)
      begin
        od_reg <= data_s[B_OD];
        abort_reg <= data_s[B_ABORT];
        pull_reg <= data_s[B_PULL];
        sra_reg <= data_s[B_SRA] && !data_s[B_BRR];
        if (data_s[B_BRR])
          brr_reg <= 1'b1;
      end
      if (wr_start && addr_s == ADDR_DATA)
      begin
        tx_hold_reg <= data_s;
        tbe_reg <= 1'b0;
      end
      // permit lives in the enable register
      if (wr_start && addr_s == ADDR_IEN)
        ien_reg <= data_s;
    end
  end

  // bus engine
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= 16'h0000;
      bit_reg <= 3'h0;
      sub_reg <= 2'h0;
      tx_shift_reg <= 8'h00;
      rx_shift_reg <= 8'h00;
      tx_shifter_empty_reg <= TX_SHIFTER_EMPTY_RST;
      wbit_reg <= 1'b1;
      b0_reg <= 1'b0;
      b2_reg <= 1'b1;
      err_reg <= 1'b0;
      pres_reg <= 1'b0;
    end
    else if (clock_en)
    begin
      // error sticks until search is turned off
      if (!sra_reg)
        err_reg <= 1'b0;
      if (abort_reg)
      begin
        state_reg <= ST_IDLE;
        cnt_reg <= 16'h0000;
        bit_reg <= 3'h0;
        sub_reg <= 2'h0;
        tx_shifter_empty_reg <= 1'b1;
      end
      else
        unique case (state_reg)
          ST_IDLE:
          begin
            cnt_reg <= 16'h0000;
            if (start_rst)
              state_reg <= ST_RST_LOW;
            else if (start_slot)
            begin
              wbit_reg <= slot_bit;
              state_reg <= ST_SLOT;
            end
            else if (load_now)
            begin
              tx_shift_reg <= tx_hold_reg;
              tx_shifter_empty_reg <= 1'b0;
              bit_reg <= 3'h0;
              sub_reg <= 2'h0;
            end
          end
          ST_SLOT:
          begin
            cnt_reg <= cnt_reg + 16'h0001;
            if (samp && !sra_reg)
              rx_shift_reg <= {sense, rx_shift_reg[7:1]};
            if (samp && sra_reg && sub_reg == 2'h0)
              b0_reg <= sense;
            if (samp && sra_reg && sub_reg == 2'h1)
            begin
              b2_reg <= b2;
              rx_shift_reg[{bit_reg[1:0], 1'b1}] <= b2;
              rx_shift_reg[{bit_reg[1:0], 1'b0}] <= none || conflict;
              if (none)
                err_reg <= 1'b1;
            end
            if (slot_end)
            begin
              state_reg <= ST_IDLE;
              if (!sra_reg)
              begin
                tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                bit_reg <= bit_reg + 3'h1;
              end
              else if (sub_reg == 2'h2)
              begin
                sub_reg <= 2'h0;
                bit_reg <= bit_reg + 3'h1;
              end
              else
                sub_reg <= sub_reg + 2'h1;
              if (last_slot)
              begin
                tx_shifter_empty_reg <= 1'b1;
                bit_reg <= 3'h0;
                sub_reg <= 2'h0;
              end
            end
          end
          ST_RST_LOW:
          begin
            cnt_reg <= cnt_reg + 16'h0001;
            if (cnt_reg == rstl_len - 16'h0001)
            begin
              cnt_reg <= 16'h0000;
              pres_reg <= 1'b0;
              state_reg <= ST_RST_WAIT;
            end
          end
          ST_RST_WAIT:
          begin
            cnt_reg <= cnt_reg + 16'h0001;
            if (cnt_reg == pres_pt)
              pres_reg <= !sense;
            if (rst_done)
              state_reg <= ST_IDLE;
          end
        endcase
    end
  end

  // outputs: host read data and open-drain line control
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      data_out_reg <= 8'h00;
      data_oe_reg <= 1'b0;
      dq_oe_reg <= 1'b0;
      dq_out_reg <= 1'b0;
    end
    else if (clock_en)
    begin
      data_oe_reg <= rd_act;
      dq_out_reg <= 1'b0;
      dq_oe_reg <= manual_active || state_reg == ST_RST_LOW
                   || (state_reg == ST_SLOT && cnt_reg < low_len);
      if (rd_start)
        unique case (addr_s)
          ADDR_CMD:
            data_out_reg <= {od_reg, 1'b0, abort_reg, 1'b0, sense, pull_reg, sra_reg, brr_reg};
          ADDR_DATA:
            data_out_reg <= rx_hold;
          ADDR_INT:
            data_out_reg <= {sense, nbsy, 1'b0, rx_holding_full, tx_shifter_empty_reg, tbe_reg, pdr_reg, pd_reg};
          ADDR_IEN:
            data_out_reg <= ien_reg;
          default:
            data_out_reg <= 8'h00;
        endcase
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  sequence s_data_write;
    clock_en && wr_start && addr_s == ADDR_DATA;
  endsequence
  sequence s_reset_request;
    clock_en && wr_start && addr_s == ADDR_CMD && data_s[B_BRR];
  endsequence
  sequence s_normal_start;
    clock_en && start_slot && !sra_reg;
  endsequence
  AST_TBE_CLEAR: assert property (s_data_write |=> !tbe_reg)
    else $error("holding empty flag not cleared by write");
  AST_LOAD: assert property (clock_en && load_now && !(wr_start && addr_s == ADDR_DATA)
    |=> tbe_reg && !tx_shifter_empty_reg)
    else $error("load did not update flags");
  AST_LSB: assert property (s_normal_start |=> wbit_reg == $past(tx_shift_reg[0]))
    else $error("bit sent is not the low shifter bit");
  AST_MANUAL: assert property (clock_en && manual_active |=> dq_oe_reg)
    else $error("manual pull low not driving line");
  AST_ABORT: assert property (clock_en && abort_reg |=> state_reg == ST_IDLE)
    else $error("abort did not idle the engine");
  AST_BUS_RESET: assert property (s_reset_request |=> brr_reg && !sra_reg)
    else $error("reset request or search clear missing");
  AST_PRESENCE: assert property (clock_en && rst_done |=> pd_reg && pdr_reg == !$past(pres_reg))
    else $error("presence flags wrong after reset");
  AST_RX_FULL: assert property (clock_en && push |=> rx_holding_full)
    else $error("receive holding not full after byte");
  AST_SEARCH_ERR: assert property (clock_en && samp && sra_reg && sub_reg == 2'h1 && err_reg
    |=> b2_reg)
    else $error("path bit not one after search error");
endmodule

// File: src/swm_pkg.sv
// shared constants for the single-wire bus master datapath
// assumes a 50 MHz system clock; counts derive from times in ns
package swm_pkg;
  localparam logic [2:0] ADDR_CMD = 3'h0;
  localparam logic [2:0] ADDR_DATA = 3'h1;
  localparam logic [2:0] ADDR_INT = 3'h2;
  localparam logic [2:0] ADDR_IEN = 3'h3;
  localparam int B_OD = 7;
  localparam int B_ABORT = 5;
  localparam int B_SENSE = 3;
  localparam int B_PULL = 2;
  localparam int B_SRA = 1;
  localparam int B_BRR = 0;
  localparam int B_PERMIT = 7;
  localparam logic TBE_RST = 1'b1;
  localparam logic TX_SHIFTER_EMPTY_RST = 1'b1;
  localparam logic PDR_RST = 1'b1;
  localparam logic [7:0] IEN_RST = 8'h00;
  // idle pin sample: strobes and line high
  localparam logic [14:0] PIN_IDLE = 15'h000f;
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 8;
  localparam int CLK_NS = 20;
  localparam int SLOT_STD_NS = 70000;
  localparam int LOW0_STD_NS = 60000;
  localparam int LOW1_STD_NS = 6000;
  localparam int SAMP_STD_NS = 15000;
  localparam int SLOT_OD_NS = 10000;
  localparam int LOW0_OD_NS = 8000;
  localparam int LOW1_OD_NS = 1000;
  localparam int SAMP_OD_NS = 2000;
  localparam int RSTL_STD_NS = 480000;
  localparam int RSTW_STD_NS = 480000;
  localparam int PRES_STD_NS = 70000;
  localparam int RSTL_OD_NS = 70000;
  localparam int RSTW_OD_NS = 48000;
  localparam int PRES_OD_NS = 8000;
  function automatic int cyc(int ns);
    return (ns + CLK_NS - 1) / CLK_NS;
  endfunction
  localparam logic [15:0] SLOT_STD_CYC = 16'(cyc(SLOT_STD_NS));
  localparam logic [15:0] LOW0_STD_CYC = 16'(cyc(LOW0_STD_NS));
  localparam logic [15:0] LOW1_STD_CYC = 16'(cyc(LOW1_STD_NS));
  localparam logic [15:0] SAMP_STD_CYC = 16'(cyc(SAMP_STD_NS));
  localparam logic [15:0] SLOT_OD_CYC = 16'(cyc(SLOT_OD_NS));
  localparam logic [15:0] LOW0_OD_CYC = 16'(cyc(LOW0_OD_NS));
  localparam logic [15:0] LOW1_OD_CYC = 16'(cyc(LOW1_OD_NS));
  localparam logic [15:0] SAMP_OD_CYC = 16'(cyc(SAMP_OD_NS));
  localparam logic [15:0] RSTL_STD_CYC = 16'(cyc(RSTL_STD_NS));
  localparam logic [15:0] RSTW_STD_CYC = 16'(cyc(RSTW_STD_NS));
  localparam logic [15:0] PRES_STD_CYC = 16'(cyc(PRES_STD_NS));
  localparam logic [15:0] RSTL_OD_CYC = 16'(cyc(RSTL_OD_NS));
  localparam logic [15:0] RSTW_OD_CYC = 16'(cyc(RSTW_OD_NS));
  localparam logic [15:0] PRES_OD_CYC = 16'(cyc(PRES_OD_NS));
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SLOT = 2'b01,
    ST_RST_LOW = 2'b10,
    ST_RST_WAIT = 2'b11
  } eng_state_e;
endpackage

// File: test/bus_slave_model.sv
// behavioural slave device hanging on the open-drain line
// assumes an external pull-up and overdrive slot timing from the master
`timescale 1ns/1ps
module bus_slave_model #(
  parameter logic [63:0] ROM = 64'h0
)(
  input wire logic clock,
  input wire logic line,
  input wire logic silent,
  input wire logic resp_en,
  input wire logic [7:0] resp,
  output logic pull,
  output logic [7:0] last_byte = 8'h00
);
  logic line_q = 1'b1;
  logic search = 1'b0;
  logic active = 1'b1;
  logic drive0 = 1'b0;
  logic [1:0] phase = 2'h0;
  logic [2:0] bit_idx = 3'h0;
  logic [5:0] pos = 6'h00;
  logic [7:0] shift = 8'h00;
  int low_cnt = 0;
  int slot_cnt = 0;
  int quiet = 0;

  // presence pulse, own zero bits pulled low
  assign pull = !silent && ((quiet > 300 && quiet < 970) ||
                            (slot_cnt > 0 && slot_cnt < 300 && drive0));

  always @(posedge clock)
  begin
    line_q <= line;
    low_cnt <= line ? 0 : low_cnt + 1;
    if (quiet > 0)
      quiet <= quiet - 1;
    if (slot_cnt > 0)
      slot_cnt <= (slot_cnt == 400) ? 0 : slot_cnt + 1;
    if (line && !line_q && low_cnt > 3200)
    begin
      quiet <= 1000;
      search <= 1'b0;
      active <= 1'b1;
      phase <= 2'h0;
      pos <= 6'h00;
      bit_idx <= 3'h0;
      slot_cnt <= 0;
    end
    else if (!line && line_q && quiet == 0)
    begin
      slot_cnt <= 1;
      // bit then complement, nothing in the write slot
      drive0 <= search ? active && (phase == 2'h0 ? !ROM[pos] : phase == 2'h1 && ROM[pos])
                       : resp_en && !resp[bit_idx];
    end
    // sampled at 200: fine for overdrive slots only
    if (slot_cnt == 200)
    begin
      if (search)
      begin
        phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
        if (phase == 2'h2)
        begin
          // losers of the written bit drop out
          if (line != ROM[pos])
            active <= 1'b0;
          pos <= pos + 6'h01;
        end
      end
      else
      begin
        shift <= {line, shift[7:1]};
        bit_idx <= bit_idx + 3'h1;
        if (bit_idx == 3'h7)
        begin
          last_byte <= {line, shift[7:1]};
          if ({line, shift[7:1]} == 8'hf0)
            search <= 1'b1;
        end
      end
    end
  end
endmodule

// File: test/single_wire_master_tb_top.sv
// self-checking bench for the single-wire master datapath
// assumes two slave models on the pulled-up line and short std reset counts
`timescale 1ns/1ps
module single_wire_master_tb_top
  import swm_pkg::*;
;
  localparam logic [63:0] ROM_A = 64'h35;
  localparam logic [63:0] ROM_B = 64'haa;
  logic clock = 0, rst = 1, en_n = 1, rd_n = 1, wr_n = 1, silent = 0, resp_en = 0, ce = 1;
  logic [2:0] addr = 3'h0;
  logic [7:0] data_in = 8'h00;
  logic [7:0] data_out, last_byte, rd_val;
  logic data_oe, dq_out, dq_oe, pull_a, pull_b, oe_seen;
  int err_count = 0, check_count = 0, cycles = 0;
  wire logic line = !dq_oe && !pull_a && !pull_b;

  single_wire_master #(.RST_LOW_CYC(16'h0028), .RST_WAIT_CYC(16'h0028)) dut_u (
    .clock(clock), .rst(rst), .clock_en(ce), .addr(addr), .en_n(en_n), .rd_n(rd_n),
    .wr_n(wr_n), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .dq_in(line), .dq_out(dq_out), .dq_oe(dq_oe));
  bus_slave_model #(.ROM(ROM_A)) slave_a (.clock(clock), .line(line), .silent(silent),
    .resp_en(resp_en), .resp(8'h5a), .pull(pull_a), .last_byte(last_byte));
  bus_slave_model #(.ROM(ROM_B)) slave_b (.clock(clock), .line(line), .silent(silent),
    .resp_en(resp_en), .resp(8'h5a), .pull(pull_b), .last_byte());

  initial
  begin
    forever #10 clock = ~clock;
  end

  task automatic summarize();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %s exp %h got %h", name, exp, got);
    end
  endtask

  task automatic host_write(input logic [2:0] a, input logic [7:0] d);
    @(negedge clock);
    addr = a;
    data_in = d;
    en_n = 0;
    wr_n = 0;
    repeat (4) @(negedge clock);
    en_n = 1;
    wr_n = 1;
    repeat (4) @(negedge clock);
  endtask

  task automatic host_read(input logic [2:0] a, output logic [7:0] d);
    @(negedge clock);
    addr = a;
    en_n = 0;
    rd_n = 0;
    repeat (6) @(negedge clock);
    d = data_out;
    oe_seen = data_oe;
    en_n = 1;
    rd_n = 1;
    repeat (4) @(negedge clock);
  endtask

  task automatic rd_chk(input string name, input logic [2:0] a, input logic [7:0] m,
                        input logic [7:0] exp);
    host_read(a, rd_val);
    chk(name, {8'h00, exp}, {8'h00, rd_val & m});
    chk("data_oe", 16'h0001, {15'h0000, oe_seen});
  endtask

  // polls are bounded; a stuck flag gives up after 1500 more reads, well short of the cycle ceiling
  task automatic wait_on(input logic [2:0] a, input logic [7:0] m, input logic [7:0] v);
    host_read(a, rd_val);
    for (int n = 0; n < 1500 && (rd_val & m) !== v; n++)
      host_read(a, rd_val);
  endtask

  task automatic low_width(input string name, input logic [15:0] exp);
    logic [15:0] n;
    n = 16'h0000;
    for (int w = 0; w < 100 && dq_oe !== 1'b1; w++)
      @(negedge clock);
    while (dq_oe === 1'b1 && n < 16'h2710)
    begin
      @(negedge clock);
      n++;
    end
    chk(name, exp, n);
  endtask

  task automatic t_regs();
    rd_chk("cmd", ADDR_CMD, 8'hff, 8'h08);
    chk("data_oe idle", 16'h0000, {15'h0000, data_oe});
    rd_chk("status", ADDR_INT, 8'hff, 8'hce);
    rd_chk("enable", ADDR_IEN, 8'hff, 8'h00);
    host_write(ADDR_IEN, 8'h5a);
    host_write(ADDR_INT, 8'h00);
    host_write(3'h6, 8'h77);
    rd_chk("enable", ADDR_IEN, 8'hff, 8'h5a);
    rd_chk("status", ADDR_INT, 8'hff, 8'hce);
    rd_chk("unmapped", 3'h6, 8'hff, 8'h00);
    host_write(ADDR_IEN, 8'h00);
  endtask

  task automatic t_manual();
    host_write(ADDR_CMD, 8'h04);
    chk("dq_oe", 16'h0000, {15'h0000, dq_oe});
    rd_chk("cmd", ADDR_CMD, 8'hff, 8'h0c);
    host_write(ADDR_IEN, 8'h80);
    chk("dq_oe", 16'h0001, {15'h0000, dq_oe});
    chk("dq_out", 16'h0000, {15'h0000, dq_out});
    // clock_en low: a strobe while frozen is never seen
    ce = 0;
    host_write(ADDR_CMD, 8'h00);
    ce = 1;
    chk("frozen dq_oe", 16'h0001, {15'h0000, dq_oe});
    rd_chk("cmd", ADDR_CMD, 8'hff, 8'h04);
    rd_chk("status", ADDR_INT, 8'h80, 8'h00);
    host_write(ADDR_CMD, 8'h00);
    chk("dq_oe", 16'h0000, {15'h0000, dq_oe});
    host_write(ADDR_IEN, 8'h00);
  endtask

  task automatic t_abort();
    // standard rate; a bus reset has already been issued
    host_write(ADDR_CMD, 8'h00);
    fork
      host_write(ADDR_DATA, 8'h00);
      low_width("std low", LOW0_STD_CYC);
    join
    // abort lands inside the second slot's low time
    for (int w = 0; w < 1000 && dq_oe !== 1'b1; w++)
      @(negedge clock);
    host_write(ADDR_CMD, 8'h20);
    chk("dq_oe", 16'h0000, {15'h0000, dq_oe});
    rd_chk("status", ADDR_INT, 8'hff, 8'hce);
    rd_chk("cmd", ADDR_CMD, 8'hff, 8'h28);
    host_write(ADDR_CMD, 8'h80);
  endtask

  task automatic t_reset(input logic s, input logic presence_result);
    silent = s;
    host_write(ADDR_CMD, 8'h82);
    fork
      host_write(ADDR_CMD, 8'h81);
      low_width("rst low", RSTL_OD_CYC);
    join
    rd_chk("cmd", ADDR_CMD, 8'hf7, 8'h81);
    wait_on(ADDR_CMD, 8'h01, 8'h00);
    rd_chk("status", ADDR_INT, 8'hff, {6'b110011, presence_result, 1'b1});
    rd_chk("status", ADDR_INT, 8'hff, {6'b110011, presence_result, 1'b0});
  endtask

  task automatic t_bytes();
    resp_en = 1;
    fork
      host_write(ADDR_DATA, 8'h35);
      low_width("od low", LOW1_OD_CYC);
    join
    rd_chk("flags", ADDR_INT, 8'h1c, 8'h04);
    host_write(ADDR_DATA, 8'hff);
    rd_chk("flags", ADDR_INT, 8'h1c, 8'h00);
    wait_on(ADDR_INT, 8'h4c, 8'h4c);
    resp_en = 0;
    rd_chk("flags", ADDR_INT, 8'h1c, 8'h1c);
    rd_chk("rx", ADDR_DATA, 8'hff, 8'h10);
    rd_chk("rx", ADDR_DATA, 8'hff, 8'h5a);
    rd_chk("flags", ADDR_INT, 8'h10, 8'h00);
    host_write(ADDR_DATA, 8'hf0);
    wait_on(ADDR_INT, 8'h4c, 8'h4c);
    chk("slave byte", 16'h00f0, {8'h00, last_byte});
    rd_chk("rx", ADDR_DATA, 8'hff, 8'hf0);
  endtask

  task automatic t_search(input logic [15:0] path);
    logic [15:0] exp;
    logic ea, eb, b0, b1, b2, err;
    ea = !silent;
    eb = !silent;
    err = 1'b0;
    // expected interleaving for the two slaves
    for (int n = 0; n < 8; n++)
    begin
      b0 = !((ea && !ROM_A[n]) || (eb && !ROM_B[n]));
      b1 = !((ea && ROM_A[n]) || (eb && ROM_B[n]));
      err = err | (b0 && b1);
      b2 = err ? 1'b1 : (!b0 && !b1) ? path[2*n+1] : b0;
      exp[2*n] = (b0 == b1);
      exp[2*n+1] = b2;
      ea = ea && (ROM_A[n] == b2);
      eb = eb && (ROM_B[n] == b2);
    end
    host_write(ADDR_CMD, 8'h82);
    host_write(ADDR_DATA, path[7:0]);
    host_write(ADDR_DATA, path[15:8]);
    wait_on(ADDR_INT, 8'h4c, 8'h4c);
    rd_chk("search rx", ADDR_DATA, 8'hff, exp[7:0]);
    rd_chk("search rx", ADDR_DATA, 8'hff, exp[15:8]);
    host_write(ADDR_CMD, 8'h80);
  endtask

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      err_count++;
      summarize();
    end
  end

  initial
  begin
    repeat (3) @(negedge clock);
    rst = 0;
    t_regs();
    t_manual();
    t_reset(1'b1, 1'b1);
    t_abort();
    t_search(16'h0000);
    t_reset(1'b0, 1'b0);
    t_bytes();
    t_search(16'h0002);
    summarize();
  end
endmodule
